// File: verilog/mem_cmd_end.sv
// memory side: command decoder, per-bank state machines, device modes
// assumes pins are synchronous to ref_clk_i, driven by the controller end
`timescale 1ns/1ps

module mem_cmd_end
    import bank_cmd_pkg::*;
#(
    parameter bit BIG_PART = 1'b1
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  clk_en_i,
    cmd_bus_if.mem                     bus,
    output logic [NUM_BANKS*3-1:0]     bank_state_o,
    output logic [2:0]                 dev_state_o,
    output logic                       odt_active_o,
    output logic                       mode_load_o,
    output logic [BA_W-1:0]            mode_sel_o,
    output logic [ADDR_W-1:0]          mode_op_o,
    output logic                       illegal_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                       cke_prev;
        dev_e                       dev;
        logic [CNT_W-1:0]           dev_cnt;
        bank_e [NUM_BANKS-1:0]      bank;
        logic [NUM_BANKS-1:0]       ap;
        logic [NUM_BANKS-1:0][CNT_W-1:0] cnt;
        logic                       odt_on;
        logic                       mode_load;
        logic [BA_W-1:0]            mode_sel;
        logic [ADDR_W-1:0]          mode_op;
        logic                       illegal;
    } mem_s;

    mem_s st_reg;
    mem_s st_next;
    cmd_e cmd;
    logic [BA_W-1:0] ba_eff;
    logic all_idle;

    assign cmd = decode_cmd(st_reg.cke_prev, bus.cke, bus.cs_n, bus.ras_n,
                            bus.cas_n, bus.we_n);
    assign ba_eff = BIG_PART ? bus.ba : {1'b0, bus.ba[BA_W-2:0]};

    always_comb begin
        all_idle = 1'b1;
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (st_reg.bank[b] != BK_IDLE)
                all_idle = 1'b0;
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.mode_load = 1'b0;
        st_next.illegal = 1'b0;
        st_next.cke_prev = bus.cke;

        // ------------------------------------------------------------
        // bank timers run whenever cke and clk_en_i are both high
        // ------------------------------------------------------------
        // per-bank update
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (bus.cke && st_reg.cnt[b] != '0)
                st_next.cnt[b] = st_reg.cnt[b] - 1'b1;
            if (bus.cke && st_reg.cnt[b] == CNT_W'(1)) begin
                case (st_reg.bank[b])
                    BK_ACTV: st_next.bank[b] = BK_ROW;
                    // trp done; a stale auto precharge mark
                    // would make a later precharge of this idle bank illegal
                    BK_PRE: begin
                        st_next.bank[b] = BK_IDLE;
                        st_next.ap[b] = 1'b0;
                    end
                    // burst over, precharge starts or row stays open
                    BK_READ, BK_WRITE: begin
                        if (st_reg.ap[b]) begin
                            st_next.bank[b] = BK_PRE;
                            st_next.cnt[b] = CNT_W'(TRP_CYC +
                                (st_reg.bank[b] == BK_WRITE ? TWR_CYC : 0));
                        end else begin
                            st_next.bank[b] = BK_ROW;
                        end
                    end
                    default: st_next.bank[b] = st_reg.bank[b];
                endcase
            end
        end

        // ------------------------------------------------------------
        // device-wide modes
        // ------------------------------------------------------------
        if (bus.cke && st_reg.dev_cnt != '0)
            st_next.dev_cnt = st_reg.dev_cnt - 1'b1;
        case (st_reg.dev)
            DV_REF, DV_MODE, DV_XSNR: begin
                if (st_reg.dev_cnt <= CNT_W'(1) && bus.cke)
                    st_next.dev = DV_RUN;
            end
            DV_SREF: begin
                if (cmd == CMD_EXIT) begin
                    st_next.dev = DV_XSNR;
                    st_next.dev_cnt = CNT_W'(TXSNR_CYC);
                end
            end
            DV_PDOWN: begin
                if (cmd == CMD_EXIT)
                    st_next.dev = DV_RUN;
            end
            DV_RUN: begin
                case (cmd)
                    // nothing registered
                    // exit also decodes at the first edge after reset
                    CMD_DESEL, CMD_NOP, CMD_EXIT: ;
                    CMD_PD_IN: st_next.dev = DV_PDOWN;
                    CMD_SREF_IN: begin
                        st_next.dev = DV_SREF;
                        st_next.illegal = !all_idle;
                    end
                    // mode load, refused unless all banks idle
                    CMD_MODE: begin
                        if (!all_idle) begin
                            st_next.illegal = 1'b1;
                        end else begin
                            st_next.dev = DV_MODE;
                            st_next.dev_cnt = CNT_W'(TMRD_CYC);
                            st_next.mode_load = 1'b1;
                            st_next.mode_sel = ba_eff;
                            st_next.mode_op = bus.addr;
                        end
                    end
                    // refresh, refused unless all banks idle
                    CMD_REFRESH: begin
                        if (!all_idle) begin
                            st_next.illegal = 1'b1;
                        end else begin
                            st_next.dev = DV_REF;
                            st_next.dev_cnt = CNT_W'(TRFC_CYC);
                        end
                    end
                    CMD_PRE: begin
                        for (int b = 0; b < NUM_BANKS; b++) begin
                            if (bus.addr[AP_BIT] || ba_eff == BA_W'(b)) begin
                                if (st_reg.bank[b] == BK_ACTV || st_reg.ap[b] &&
                                    st_reg.bank[b] != BK_ROW) begin
                                    st_next.illegal = 1'b1;
                                end else if (st_reg.bank[b] != BK_IDLE) begin
                                    st_next.bank[b] = BK_PRE;
                                    st_next.cnt[b] = CNT_W'(TRP_CYC);
                                end
                            end
                        end
                    end
                    CMD_ACT: begin
                        if (st_reg.bank[ba_eff] != BK_IDLE) begin
                            st_next.illegal = 1'b1;
                        end else begin
                            st_next.bank[ba_eff] = BK_ACTV;
                            st_next.cnt[ba_eff] = CNT_W'(TRCD_CYC);
                            st_next.ap[ba_eff] = 1'b0;
                        end
                    end
                    // column address not tracked, only a10
                    // row open or burst running; not in auto precharge
                    CMD_READ, CMD_WRITE: begin
                        if (!(st_reg.bank[ba_eff] inside {BK_ROW, BK_READ, BK_WRITE})
                            || st_reg.ap[ba_eff]
                            // write is refused while the read burst runs
                            || (cmd == CMD_WRITE && st_reg.bank[ba_eff] == BK_READ)) begin
                            st_next.illegal = 1'b1;
                        end else begin
                            st_next.bank[ba_eff] = (cmd == CMD_READ) ? BK_READ : BK_WRITE;
                            st_next.cnt[ba_eff] = CNT_W'(BURST_CYC);
                            st_next.ap[ba_eff] = bus.addr[AP_BIT];
                        end
                    end
                    default: st_next.illegal = 1'b1;
                endcase
            end
            default: st_next.dev = DV_RUN;
        endcase
        if (st_reg.dev inside {DV_REF, DV_MODE, DV_XSNR} &&
            !(cmd inside {CMD_DESEL, CMD_NOP}))
            st_next.illegal = 1'b1;
        // termination gate, from the new mode so entry cuts it at once
        st_next.odt_on = bus.odt && (st_next.dev != DV_SREF);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else if (clk_en_i) begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++)
            bank_state_o[b*3 +: 3] = st_reg.bank[b];
    end
    assign dev_state_o  = st_reg.dev;
    assign odt_active_o = st_reg.odt_on;
    assign mode_load_o  = st_reg.mode_load;
    assign mode_sel_o   = st_reg.mode_sel;
    assign mode_op_o    = st_reg.mode_op;
    assign illegal_o    = st_reg.illegal;

endmodule : mem_cmd_end

// File: verilog/bank_cmd_pkg.sv
// constants and types shared by the command-bus interface and both ends
// assumes one 40 MHz command clock common to controller and memory end
package bank_cmd_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int NUM_BANKS = 8;
    localparam int BA_W      = 3;
    localparam int ADDR_W    = 14;
    localparam int AP_BIT    = 10;
    localparam int CNT_W     = 8;

    // ------------------------------------------------------------
    // timing, ns as nominal figures, and derived cycle counts
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int TRCD_NS       = 15;
    localparam int TRP_NS        = 15;
    localparam int TRFC_NS       = 105;
    localparam int TXSNR_NS      = 115;
    localparam int TMRD_CYC      = 2;
    localparam int BURST_CYC     = 2;
    localparam int TWR_NS        = 15;
    // least times round up
    localparam int TRCD_CYC  = (TRCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRP_CYC   = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRFC_CYC  = (TRFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TXSNR_CYC = (TXSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TWR_CYC   = (TWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // decoded commands, bank states and device states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_DESEL   = 4'h0,
        CMD_NOP     = 4'h1,
        CMD_MODE    = 4'h2,
        CMD_REFRESH = 4'h3,
        CMD_SREF_IN = 4'h4,
        CMD_PRE     = 4'h5,
        CMD_ACT     = 4'h6,
        CMD_WRITE   = 4'h7,
        CMD_READ    = 4'h8,
        CMD_PD_IN   = 4'h9,
        CMD_EXIT    = 4'ha,
        CMD_BAD     = 4'hf
    } cmd_e;

    typedef enum logic [2:0] {
        BK_IDLE  = 3'h0,
        BK_ACTV  = 3'h1,
        BK_ROW   = 3'h2,
        BK_READ  = 3'h3,
        BK_WRITE = 3'h4,
        BK_PRE   = 3'h5
    } bank_e;

    typedef enum logic [2:0] {
        DV_RUN   = 3'h0,
        DV_REF   = 3'h1,
        DV_MODE  = 3'h2,
        DV_SREF  = 3'h3,
        DV_PDOWN = 3'h4,
        DV_XSNR  = 3'h5
    } dev_e;

    // decode of the control pins, used by the memory end
    function automatic cmd_e decode_cmd(input logic cke_prev, input logic cke,
                                        input logic cs_n, input logic ras_n,
                                        input logic cas_n, input logic we_n);
        logic desnop;
        desnop = cs_n | (ras_n & cas_n & we_n);
        if (!cke_prev && cke && desnop)
            return CMD_EXIT;
        if (!cke_prev)
            return CMD_DESEL;
        if (!cke && desnop)
            return CMD_PD_IN;
        if (!cke && !cs_n && !ras_n && !cas_n && we_n)
            return CMD_SREF_IN;
        if (!cke)
            return CMD_BAD;
        if (cs_n)
            return CMD_DESEL;
        case ({ras_n, cas_n, we_n})
            3'h7:    return CMD_NOP;
            3'h0:    return CMD_MODE;
            3'h1:    return CMD_REFRESH;
            3'h2:    return CMD_PRE;
            3'h3:    return CMD_ACT;
            3'h4:    return CMD_WRITE;
            3'h5:    return CMD_READ;
            default: return CMD_BAD;
        endcase
    endfunction : decode_cmd

endpackage : bank_cmd_pkg

// File: verilog/cmd_bus_if.sv
// command bus between memory controller and memory command end
// assumes both ends clocked by the same ref_clk_i
`timescale 1ns/1ps
interface cmd_bus_if;
    import bank_cmd_pkg::*;
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    logic              odt;

    modport ctrl (output cke, output cs_n, output ras_n, output cas_n,
                  output we_n, output ba, output addr, output odt);
    modport mem  (input cke, input cs_n, input ras_n, input cas_n,
                  input we_n, input ba, input addr, input odt);
endinterface : cmd_bus_if

// File: verilog/ctrl_cmd_end.sv
// controller side: turns one user request into one pin command
// assumes user waits for ready_o; timing between requests is the user's job
`timescale 1ns/1ps
module ctrl_cmd_end
    import bank_cmd_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              clk_en_i,
    input  wire logic              req_i,
    input  wire logic [3:0]        req_cmd_i,
    input  wire logic [BA_W-1:0]   req_ba_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic              req_odt_i,
    output logic                   ready_o,
    cmd_bus_if.ctrl                bus
);

    typedef struct packed {
        logic              cke;
        logic [3:0]        pins;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] addr;
        logic              odt;
        logic              ready;
    } ctl_s;

    ctl_s st_reg;
    ctl_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.pins = 4'h7;
        st_next.ready = 1'b1;
        st_next.odt = req_odt_i;
        if (req_i) begin
            st_next.ba = req_ba_i;
            st_next.addr = req_addr_i;
            // only listed encodings leave this block
            case (cmd_e'(req_cmd_i))
                CMD_MODE:    st_next.pins = 4'h0;
                CMD_REFRESH: st_next.pins = 4'h1;
                CMD_PRE:     st_next.pins = 4'h2;
                CMD_ACT:     st_next.pins = 4'h3;
                CMD_WRITE:   st_next.pins = 4'h4;
                CMD_READ:    st_next.pins = 4'h5;
                CMD_DESEL:   st_next.pins = 4'h8;
                // cke falls with refresh or nop
                CMD_SREF_IN: begin
                    st_next.pins = 4'h1;
                    st_next.cke = 1'b0;
                end
                CMD_PD_IN:   st_next.cke = 1'b0;
                CMD_EXIT:    st_next.cke = 1'b1;
                default:     st_next.pins = 4'h7;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '{cke: 1'b1, pins: 4'h8, ba: '0, addr: '0, odt: 1'b0, ready: 1'b0};
        end else if (clk_en_i) begin
            st_reg <= st_next;
        end
    end

    assign bus.cke   = st_reg.cke;
    assign bus.cs_n  = st_reg.pins[3];
    assign bus.ras_n = st_reg.pins[2];
    assign bus.cas_n = st_reg.pins[1];
    assign bus.we_n  = st_reg.pins[0];
    assign bus.ba    = st_reg.ba;
    assign bus.addr  = st_reg.addr;
    assign bus.odt   = st_reg.odt;
    assign ready_o   = st_reg.ready;

endmodule : ctrl_cmd_end

// File: testbench/bank_cmd_checker.sv
// checker: command pins against the memory end's bank and device results
// assumes one clock domain; instantiated in tb_top beside cmd_bus_if
`timescale 1ns/1ps
module bank_cmd_checker
    import bank_cmd_pkg::*;
(
    input wire logic                   ref_clk_i,
    input wire logic                   rst_n_i,
    input wire logic                   clk_en_i,
    input wire logic                   cke,
    input wire logic                   cs_n,
    input wire logic                   ras_n,
    input wire logic                   cas_n,
    input wire logic                   we_n,
    input wire logic [BA_W-1:0]        ba,
    input wire logic [ADDR_W-1:0]      addr,
    input wire logic [NUM_BANKS*3-1:0] bank_state_o,
    input wire logic [2:0]             dev_state_o,
    input wire logic                   odt_active_o,
    input wire logic                   mode_load_o,
    input wire logic [BA_W-1:0]        mode_sel_o,
    input wire logic [ADDR_W-1:0]      mode_op_o,
    input wire logic                   illegal_o
);
    // ------------------------------------------------------------
    // pin decode; cke history mirrors the memory end after reset
    // ------------------------------------------------------------
    logic            cke_prev_reg;
    logic [BA_W-1:0] ba_reg;
    logic            run, ok, nop, desnop, act, rd, wr, pre, mode, rfr, idle;
    logic [2:0]      tgt, cur;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cke_prev_reg <= 1'b0;
            ba_reg       <= '0;
        end else if (clk_en_i) begin
            cke_prev_reg <= cke;
            if (ok && !nop)
                ba_reg <= ba;
        end
    end
    assign run    = clk_en_i && dev_state_o == DV_RUN;
    assign ok     = run && cke_prev_reg && cke && !cs_n;
    assign nop    = ras_n && cas_n && we_n;
    assign desnop = cs_n || nop;
    assign act    = ok && !ras_n && cas_n && we_n;
    assign rd     = ok && ras_n && !cas_n && we_n;
    assign wr     = ok && ras_n && !cas_n && !we_n;
    assign pre    = ok && !ras_n && cas_n && !we_n;
    assign mode   = ok && !ras_n && !cas_n && !we_n;
    assign rfr    = ok && !ras_n && !cas_n && we_n;
    assign idle   = bank_state_o == '0;
    assign tgt    = bank_state_o[ba*3 +: 3];
    // bank of the last real command; valid while no other bank is addressed
    assign cur    = bank_state_o[ba_reg*3 +: 3];

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_open;
        bank_state_o[$past(ba)*3 +: 3] == BK_ACTV
        ##1 bank_state_o[$past(ba, 2)*3 +: 3] == BK_ROW;
    endsequence
    sequence s_busy;
        (cur != BK_IDLE) [*2];
    endsequence

    a_mode_load: assert property (
        mode && idle |=> mode_load_o && mode_sel_o == $past(ba) && mode_op_o == $past(addr))
        else $error("mode load not reported");
    a_act_opens: assert property (
        act && tgt == BK_IDLE |=> s_open) else $error("activate did not open bank");
    a_act_refused: assert property (
        act && tgt != BK_IDLE |=> illegal_o && cur == $past(tgt))
        else $error("activate to busy bank accepted");
    a_read_burst: assert property (
        rd && !addr[AP_BIT] && tgt == BK_ROW |=> cur == BK_READ ##[1:3] cur == BK_ROW)
        else $error("read burst not tracked");
    a_auto_pre: assert property (
        (rd || wr) && addr[AP_BIT] && tgt == BK_ROW |=> s_busy ##[1:8] cur == BK_IDLE)
        else $error("auto precharge not tracked");
    a_pre_one: assert property (
        pre && !addr[AP_BIT] && tgt == BK_ROW |=> cur == BK_PRE ##1 cur == BK_IDLE)
        else $error("precharge did not close bank");
    a_pre_all: assert property (
        pre && addr[AP_BIT] |=> ##[1:3] idle) else $error("precharge all left banks open");
    a_refresh: assert property (
        rfr && idle |=> dev_state_o == DV_REF ##[1:6] dev_state_o == DV_RUN && idle)
        else $error("refresh not tracked");
    a_sref_entry: assert property (
        run && cke_prev_reg && !cke && !cs_n && !ras_n && !cas_n && we_n
        |=> dev_state_o == DV_SREF) else $error("self refresh not entered");
    a_pdown_entry: assert property (
        run && cke_prev_reg && !cke && desnop && idle |=> dev_state_o == DV_PDOWN)
        else $error("power-down not entered");
    a_sref_no_odt: assert property (
        dev_state_o == DV_SREF |-> !odt_active_o) else $error("termination in self refresh");
    a_nop_holds: assert property (
        ok && nop && idle |=> idle) else $error("no-op changed bank state");
endmodule : bank_cmd_checker

// File: testbench/tb_top.sv
// self-checking bench: controller end drives the memory end over cmd_bus_if
// assumes package timing figures and a 40 MHz clock
`timescale 1ns/1ps
module tb_top;
    import bank_cmd_pkg::*;
    logic                   ref_clk_i;
    logic                   rst_n_i;
    logic                   clk_en;
    logic                   req;
    logic [3:0]             req_cmd;
    logic [BA_W-1:0]        req_ba;
    logic [ADDR_W-1:0]      req_addr;
    logic                   req_odt;
    logic                   odt_on;
    logic                   ready;
    logic [NUM_BANKS*3-1:0] bank_state;
    logic [2:0]             dev_state;
    logic                   odt_active, mode_load, illegal;
    logic [BA_W-1:0]        mode_sel;
    logic [ADDR_W-1:0]      mode_op;
    int                     n_errors, checks, cycles;

    cmd_bus_if bus ();
    ctrl_cmd_end i_ctrl_cmd_end (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en),
        .req_i(req), .req_cmd_i(req_cmd), .req_ba_i(req_ba), .req_addr_i(req_addr),
        .req_odt_i(req_odt), .ready_o(ready), .bus(bus));
    mem_cmd_end #(.BIG_PART(1'b1)) i_mem_cmd_end (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .clk_en_i(clk_en), .bus(bus), .bank_state_o(bank_state), .dev_state_o(dev_state),
        .odt_active_o(odt_active), .mode_load_o(mode_load), .mode_sel_o(mode_sel),
        .mode_op_o(mode_op), .illegal_o(illegal));
    bank_cmd_checker i_bank_cmd_checker (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .clk_en_i(clk_en), .cke(bus.cke), .cs_n(bus.cs_n), .ras_n(bus.ras_n),
        .cas_n(bus.cas_n), .we_n(bus.we_n), .ba(bus.ba), .addr(bus.addr),
        .bank_state_o(bank_state), .dev_state_o(dev_state), .odt_active_o(odt_active),
        .mode_load_o(mode_load), .mode_sel_o(mode_sel), .mode_op_o(mode_op),
        .illegal_o(illegal));

    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // ------------------------------------------------------------
    // request and compare tasks
    // ------------------------------------------------------------
    task automatic issue(input logic [3:0] c, input logic [BA_W-1:0] b,
                         input logic [ADDR_W-1:0] a);
        @(posedge ref_clk_i);
        req      <= 1'b1;
        req_cmd  <= c;
        req_ba   <= b;
        req_addr <= a;
        req_odt  <= odt_on;
    endtask : issue
    // results are read 1 ns after the edge so its updates have landed
    task automatic pause(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            req <= 1'b0;
        end
        #1;
    endtask : pause
    task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : compare
    task automatic chk_bank(input int b, input bank_e e);
        compare("bank state", 16'(e), 16'(bank_state[b*3 +: 3]));
    endtask : chk_bank
    task automatic chk_dev(input dev_e e);
        compare("device state", 16'(e), 16'(dev_state));
    endtask : chk_dev
    task automatic wait_bank(input int b, input bank_e e, input int lim);
        for (int i = 0; i < lim && bank_state[b*3 +: 3] !== e; i++)
            pause(1);
        chk_bank(b, e);
    endtask : wait_bank
    task automatic wait_dev(input dev_e e, input int lim);
        for (int i = 0; i < lim && dev_state !== e; i++)
            pause(1);
        chk_dev(e);
    endtask : wait_dev
    task automatic test_done;
        $display("checks %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    // hang guard: the sequence needs under two hundred cycles
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            test_done();
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rst_n_i  = 1'b0;
        clk_en   = 1'b1;
        req      = 1'b0;
        req_cmd  = 4'h0;
        req_ba   = 3'h0;
        req_addr = 14'h0000;
        req_odt  = 1'b0;
        odt_on   = 1'b0;
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        pause(2);
        compare("ready", 16'h1, 16'(ready));
        for (int b = 0; b < 4; b++) begin
            issue(CMD_MODE, b[2:0], {11'h000, b[2:0]} ^ 14'h2a50);
            pause(2);
            compare("mode load", 16'h1, 16'(mode_load));
            compare("mode select", 16'(b[2:0]), 16'(mode_sel));
            compare("mode code", 16'({11'h000, b[2:0]} ^ 14'h2a50), 16'(mode_op));
            pause(2);
        end
        $display("test mode load done");
        issue(CMD_ACT, 3'h5, 14'h0123);
        pause(2);
        chk_bank(5, BK_ACTV);
        pause(1);
        chk_bank(5, BK_ROW);
        issue(CMD_ACT, 3'h5, 14'h0321);
        pause(2);
        compare("illegal", 16'h1, 16'(illegal));
        chk_bank(5, BK_ROW);
        issue(CMD_READ, 3'h5, 14'h0010);
        pause(2);
        chk_bank(5, BK_READ);
        wait_bank(5, BK_ROW, 4);
        issue(CMD_WRITE, 3'h5, 14'h0020);
        pause(1);
        // two-cycle burst: the second write lands just as the first ends
        issue(CMD_WRITE, 3'h5, 14'h0024);
        pause(2);
        chk_bank(5, BK_WRITE);
        wait_bank(5, BK_ROW, 6);
        issue(CMD_PRE, 3'h5, 14'h0000);
        pause(2);
        chk_bank(5, BK_PRE);
        pause(1);
        chk_bank(5, BK_IDLE);
        $display("test bank cycle done");
        issue(CMD_ACT, 3'h5, 14'h0040);
        pause(3);
        issue(CMD_READ, 3'h5, 14'h0400);
        issue(CMD_READ, 3'h5, 14'h0000);
        pause(2);
        compare("illegal", 16'h1, 16'(illegal));
        chk_bank(5, BK_READ);
        wait_bank(5, BK_IDLE, 8);
        $display("test auto precharge done");
        issue(CMD_ACT, 3'h2, 14'h0011);
        issue(CMD_ACT, 3'h7, 14'h0022);
        pause(3);
        chk_bank(7, BK_ROW);
        issue(CMD_PRE, 3'h0, 14'h0400);
        wait_bank(2, BK_IDLE, 4);
        chk_bank(7, BK_IDLE);
        $display("test precharge all done");
        issue(CMD_REFRESH, 3'h0, 14'h0000);
        issue(CMD_ACT, 3'h0, 14'h0000);
        pause(2);
        chk_dev(DV_REF);
        compare("illegal", 16'h1, 16'(illegal));
        wait_dev(DV_RUN, 8);
        chk_bank(0, BK_IDLE);
        $display("test refresh done");
        odt_on = 1'b1;
        issue(CMD_NOP, 3'h0, 14'h0000);
        pause(3);
        compare("odt active", 16'h1, 16'(odt_active));
        issue(CMD_SREF_IN, 3'h0, 14'h0000);
        pause(3);
        chk_dev(DV_SREF);
        compare("odt active", 16'h0, 16'(odt_active));
        issue(CMD_EXIT, 3'h0, 14'h0000);
        pause(2);
        chk_dev(DV_XSNR);
        // clock enable low must hold the exit count where it stands
        @(posedge ref_clk_i);
        clk_en <= 1'b0;
        pause(8);
        chk_dev(DV_XSNR);
        @(posedge ref_clk_i);
        clk_en <= 1'b1;
        wait_dev(DV_RUN, 8);
        $display("test self refresh done");
        issue(CMD_PD_IN, 3'h0, 14'h0000);
        pause(2);
        chk_dev(DV_PDOWN);
        issue(CMD_EXIT, 3'h0, 14'h0000);
        pause(2);
        chk_dev(DV_RUN);
        $display("test power-down done");
        test_done();
    end
endmodule : tb_top
